// [bench/fis_rx_tb.sv]
/* Bench for the setup and device-bits receive handler.
   Assumes the device model in sata_dev_model.sv; the bench is the APB master. */
`timescale 1ns/10ps
`default_nettype none
module fis_rx_tb;
    import fis_rx_pkg::*;
    logic              sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, perr;
    logic [7:0]        paddr = '0;
    logic [31:0]       pwdata = '0, prdata, swb = '0, maddr, rdat;
    logic              pready, pslverr, rx_ready, irq;
    setup_frame_type   s_in = '0, setup_fis;
    devbits_frame_type d_in = '0, devbits_fis;
    mem_req_type       mem_req;
    exit_type          exit_pulse, ex;
    int                bad_count = 0, cmp_count = 0, cyc = 0;
    fis_rx i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .setup_fis(setup_fis), .devbits_fis(devbits_fis),
        .slot_write_bits(swb), .rx_ready(rx_ready), .mem_req(mem_req),
        .exit_pulse(exit_pulse), .irq(irq));
    sata_dev_model i_dev (.sys_clk(sys_clk), .rx_ready(rx_ready), .s_in(s_in),
        .d_in(d_in), .setup_fis(setup_fis), .devbits_fis(devbits_fis));
    initial forever #25 sys_clk = ~sys_clk;
    // Hang guard, far above the roughly 120 cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            final_report;
        end
    end
    task final_report;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    // Offer a frame, then catch the store address and the exit pulse
    task send(input setup_frame_type s, input devbits_frame_type d);
        int n;
        s_in <= s;
        d_in <= d;
        @(posedge sys_clk);
        s_in <= '0;
        d_in <= '0;
        maddr = '1;
        ex = EXIT_NONE;
        n = 0;
        while (ex == EXIT_NONE && n < 40) begin
            @(posedge sys_clk);
            n++;
            if (mem_req.valid === 1'b1)
                maddr = mem_req.addr;
            if (exit_pulse !== EXIT_NONE)
                ex = exit_pulse;
        end
    endtask
    task t_setup;
        apb(1'b1, FISBASE_ADDR, 32'h1000);
        apb(1'b1, CTRL_ADDR, 32'h3);
        swb <= 32'h20;
        send('{1'b1, 4'h3, 5'h05, 32'h1234, 1'b1, 1'b1}, '0);
        chk(maddr, 32'h1300);
        chk(32'(ex), 32'(EXIT_DATA_TX));
        rd(SLOT_ADDR, 32'h305);
        rd(DMACNT_ADDR, 32'h1234);
        rd(STATUS_ADDR, 32'h5);
        chk(32'(irq), 32'h1);
        apb(1'b1, STATUS_ADDR, 32'h5);
        chk(32'(irq), 32'h0);
        apb(1'b1, CTRL_ADDR, 32'h8);
        swb <= 32'h0;
        send('{1'b1, 4'h3, 5'h05, 32'h10, 1'b0, 1'b1}, '0);
        chk(32'(ex), 32'(EXIT_SWITCH_IDLE));
        rd(STATUS_ADDR, 32'h0);
    endtask
    task t_sdb;
        apb(1'b1, CTRL_ADDR, 32'h35);
        apb(1'b1, ACTIVE_ADDR, 32'hf);
        send('0, '{1'b1, 4'h3, 8'h8e, 8'h5a, 32'h5, 1'b1, 1'b1});
        chk(maddr, 32'h1340);
        chk(32'(ex), 32'(EXIT_POWER_CHECK));
        rd(TASKFILE_ADDR, 32'h5a0e);
        rd(ACTIVE_ADDR, 32'ha);
        rd(NOTIFY_ADDR, 32'h8);
        rd(COALESCE_ADDR, 32'h2);
        rd(DMACNT_ADDR, 32'h0);
        rd(STATUS_ADDR, 32'h6);
        chk(32'(irq), 32'h1);
    endtask
    task t_ends;
        apb(1'b1, STATUS_ADDR, 32'h7);
        apb(1'b1, NOTIFY_ADDR, 32'hffffffff);
        apb(1'b1, CTRL_ADDR, 32'h8);
        send('0, '{1'b1, 4'h2, 8'h00, 8'h00, 32'h0, 1'b1, 1'b1});
        chk(32'(ex), 32'(EXIT_SWITCH_IDLE));
        rd(NOTIFY_ADDR, 32'h0);
        rd(STATUS_ADDR, 32'h2);
        send('0, '{1'b1, 4'h2, 8'h01, 8'h04, 32'h0, 1'b0, 1'b0});
        chk(32'(ex), 32'(EXIT_FATAL_TF));
        apb(1'b1, CTRL_ADDR, 32'h0);
        send('{1'b1, 4'h1, 5'h02, 32'h8, 1'b1, 1'b0}, '0);
        chk(32'(ex), 32'(EXIT_PORT_IDLE));
        rd(STATUS_ADDR, 32'h3);
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(32'(rx_ready), 32'h1);
        rd(TASKFILE_ADDR, 32'h7f);
        rd(8'h40, 32'h0);
        chk(32'(perr), 32'h1);
        t_setup;
        t_sdb;
        t_ends;
        final_report;
    end
endmodule
`default_nettype wire

// [bench/sata_dev_model.sv]
/* Link-side device model: offers one frame at a time, held until taken.
   Assumes the bench loads a request for one cycle and one kind at a time. */
`timescale 1ns/10ps
`default_nettype none
module sata_dev_model (
    input  wire logic                          sys_clk,
    input  wire logic                          rx_ready,
    input  wire fis_rx_pkg::setup_frame_type   s_in,
    input  wire fis_rx_pkg::devbits_frame_type d_in,
    output var  fis_rx_pkg::setup_frame_type   setup_fis = '0,
    output var  fis_rx_pkg::devbits_frame_type devbits_fis = '0
);
    import fis_rx_pkg::*;
    // Once taken, fields are scrambled so a stale frame is never trusted
    always @(posedge sys_clk) begin
        if (setup_fis.valid && rx_ready)
            setup_fis <= {1'b0, ~setup_fis[$bits(setup_fis)-2:0]};
        else if (s_in.valid)
            setup_fis <= s_in;
        if (devbits_fis.valid && rx_ready && !setup_fis.valid)
            devbits_fis <= {1'b0, ~devbits_fis[$bits(devbits_fis)-2:0]};
        else if (d_in.valid)
            devbits_fis <= d_in;
    end
endmodule
`default_nettype wire

// [core/fis_rx.sv]
/*
 * Receive handling for DMA Setup and Set Device Bits frames of one port,
 * with an APB register slave. Frames arrive already checked as well
 * formed; the memory writer copies the frame it was just handed to the
 * address given on mem_req. Exits are one-cycle pulses to the port FSM.
 */
// Notes on behaviour
// R1: setup handling starts only on a well-formed DMA Setup frame
// R2: setup frame tag saved as data command slot for current multiplier port
// R3: setup frame transfer count loads that port's remaining DMA count
// R4: setup frame stored at base plus port times 256 plus setup area offset
// R5: interrupt bit set goes to setup interrupt step, else auto-activate
// R6: setup status flag set; enable decides summary step or auto-activate
// R7: summary bit set; global enable generates interrupt, else auto-activate
// R8: after interrupt go to auto-activate; interrupt held until software clears
// R9: write slot with auto-activate starts data send; else switching or port idle
// R10: device-bits frame copied to its received area in memory
// R11: task-file status takes non-reserved status bits of the frame
// R12: task-file error loaded from frame error field
// R13: active tags cleared by frame SActive; SActive kept as completed mask
// R14: device-bits frame clears remaining DMA count of current port
// R15: updated status error bit forces fatal task-file exit first
// R16: notify path if supported with notify and irq bits; else irq or power
// R17: notify step sets notify bit for frame's port, then interrupt step
// R18: notify step only with notify bit and notification support
// R19: device-bits interrupt step only on irq frames; sets its status flag
// R20: then coalescing, summary if enabled, idle if mask zero, else power
// R21: coalescing adds completed mask popcount, then summary or power check
// R22: summary bit set; interrupt if enabled, else idle on zero mask or power
// R23: after interrupt, idle on zero mask, else power check
`timescale 1ns/10ps
`default_nettype none

module fis_rx #(
    parameter int PMP_PORTS = 16
) (
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Frames from the link side
    input  wire fis_rx_pkg::setup_frame_type   setup_fis,
    input  wire fis_rx_pkg::devbits_frame_type devbits_fis,
    input  wire logic [31:0]                 slot_write_bits,
    output logic                             rx_ready,
    // Memory store, exit and interrupt
    output fis_rx_pkg::mem_req_type          mem_req,
    output fis_rx_pkg::exit_type             exit_pulse,
    output logic                             irq
);
    import fis_rx_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, DS_ENTRY, DS_SETINTR, DS_SETIS, DS_GENINTR, DS_AUTO,
        SDB_ENTRY, SDB_DECIDE, SDB_NOTIFY, SDB_SETINTR, SDB_CCC,
        SDB_SETIS, SDB_GENINTR
    } state_type;

    // Count of ones in a completed-tag mask
    function automatic logic [5:0] popcount(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) begin
            n = n + {5'h00, v[i]};
        end
        return n;
    endfunction

    // Idle exit chosen by FIS switching
    function automatic exit_type idle_exit(input logic fbs);
        return fbs ? EXIT_SWITCH_IDLE : EXIT_PORT_IDLE;
    endfunction

    state_type                 state_r, state_nxt;
    exit_type                  exit_nxt;
    setup_frame_type           setup_r;
    devbits_frame_type         sdb_r;
    logic [CTRL_WIDTH-1:0]     ctrl_r;
    logic                      dss_r, sdbs_r, ips_r, irq_r;
    logic [7:0]                tf_sts_r, tf_err_r;
    logic [31:0]               active_r, completed_r, notify_r, ccc_r, fis_base_r;
    logic [4:0]                slot_r [PMP_PORTS];
    logic [31:0]               dma_cnt_r [PMP_PORTS];
    logic [3:0]                pmp_cur_r;
    logic                      pready_r, pslverr_r;
    logic [31:0]               prdata_r;
    mem_req_type               mem_req_r;
    exit_type                  exit_r;
    logic                      rx_ready_r;
    logic                      apb_wr, apb_rd;
    logic                      setup_take, sdb_take;
    logic                      mask_zero;

    // ---------------------------------------------------------------
    // Frame intake
    // ---------------------------------------------------------------
    // Setup wins if both offer in one cycle; devbits waits on rx_ready
    assign setup_take = setup_fis.valid && rx_ready_r && state_r == ST_IDLE; // [R1]
    assign sdb_take   = devbits_fis.valid && rx_ready_r && state_r == ST_IDLE && !setup_fis.valid;
    assign mask_zero  = completed_r == 32'h0000_0000;

    // Frame capture and current multiplier port
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            setup_r   <= '0;
            sdb_r     <= '0;
            pmp_cur_r <= 4'h0;
        end else if (setup_take) begin
            setup_r   <= setup_fis;
            pmp_cur_r <= setup_fis.pmp;
        end else if (sdb_take) begin
            sdb_r     <= devbits_fis;
            pmp_cur_r <= devbits_fis.pmp;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        exit_nxt  = EXIT_NONE;
        unique case (state_r)
            ST_IDLE: begin
                if (setup_take) state_nxt = DS_ENTRY;
                else if (sdb_take) state_nxt = SDB_ENTRY;
            end
            DS_ENTRY:   state_nxt = setup_r.irq ? DS_SETINTR : DS_AUTO; // [R5]
            DS_SETINTR: state_nxt = ctrl_r[CTRL_DSE_BIT] ? DS_SETIS : DS_AUTO; // [R6]
            DS_SETIS:   state_nxt = ctrl_r[CTRL_GIE_BIT] ? DS_GENINTR : DS_AUTO; // [R7]
            DS_GENINTR: state_nxt = DS_AUTO; // [R8]
            DS_AUTO: begin
                state_nxt = ST_IDLE;
                // [R9]
                if (slot_write_bits[slot_r[pmp_cur_r]] && setup_r.auto_act) begin
                    exit_nxt = EXIT_DATA_TX;
                end else begin
                    exit_nxt = idle_exit(ctrl_r[CTRL_FBS_BIT]);
                end
            end
            SDB_ENTRY:  state_nxt = SDB_DECIDE;
            SDB_DECIDE: begin
                if (tf_sts_r[TF_ERR_BIT]) begin // [R15]
                    state_nxt = ST_IDLE;
                    exit_nxt  = EXIT_FATAL_TF;
                end else if (ctrl_r[CTRL_NTF_BIT] && sdb_r.notify && sdb_r.irq) begin
                    state_nxt = SDB_NOTIFY; // [R16] [R18]
                end else if (sdb_r.irq) begin
                    state_nxt = SDB_SETINTR; // [R19]
                end else begin
                    state_nxt = ST_IDLE;
                    exit_nxt  = EXIT_POWER_CHECK;
                end
            end
            SDB_NOTIFY: state_nxt = SDB_SETINTR; // [R17]
            SDB_SETINTR: begin
                // [R20]
                if (ctrl_r[CTRL_CCC_BIT] && !mask_zero) begin
                    state_nxt = SDB_CCC;
                end else if (ctrl_r[CTRL_SDBE_BIT]) begin
                    state_nxt = SDB_SETIS;
                end else begin
                    state_nxt = ST_IDLE;
                    exit_nxt  = mask_zero ? idle_exit(ctrl_r[CTRL_FBS_BIT]) : EXIT_POWER_CHECK;
                end
            end
            SDB_CCC: begin
                // [R21]
                if (ctrl_r[CTRL_SDBE_BIT]) begin
                    state_nxt = SDB_SETIS;
                end else begin
                    state_nxt = ST_IDLE;
                    exit_nxt  = EXIT_POWER_CHECK;
                end
            end
            SDB_SETIS: begin
                // [R22]
                if (ctrl_r[CTRL_GIE_BIT]) begin
                    state_nxt = SDB_GENINTR;
                end else begin
                    state_nxt = ST_IDLE;
                    exit_nxt  = mask_zero ? idle_exit(ctrl_r[CTRL_FBS_BIT]) : EXIT_POWER_CHECK;
                end
            end
            SDB_GENINTR: begin
                // [R23]
                state_nxt = ST_IDLE;
                exit_nxt  = mask_zero ? idle_exit(ctrl_r[CTRL_FBS_BIT]) : EXIT_POWER_CHECK;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // State, exit pulse and intake ready
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r    <= ST_IDLE;
            exit_r     <= EXIT_NONE;
            rx_ready_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            exit_r     <= exit_nxt;
            rx_ready_r <= state_nxt == ST_IDLE;
        end
    end

    // ---------------------------------------------------------------
    // Per multiplier port slot and byte count
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < PMP_PORTS; i++) begin
                slot_r[i]    <= 5'h00;
                dma_cnt_r[i] <= 32'h0000_0000;
            end
        end else if (state_r == DS_ENTRY) begin
            slot_r[pmp_cur_r]    <= setup_r.tag; // [R2]
            dma_cnt_r[pmp_cur_r] <= setup_r.count; // [R3]
        end else if (state_r == SDB_ENTRY) begin
            dma_cnt_r[pmp_cur_r] <= 32'h0000_0000; // [R14]
        end
    end

    // Frame store requests, one cycle each
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mem_req_r <= '0;
        end else begin
            mem_req_r.valid   <= state_r == DS_ENTRY || state_r == SDB_ENTRY; // [R4] [R10]
            mem_req_r.devbits <= state_r == SDB_ENTRY;
            mem_req_r.addr    <= fis_base_r + {24'h000000, pmp_cur_r, 4'h0} * PMP_STRIDE[31:4]
                               + (state_r == SDB_ENTRY ? DEVBITS_AREA : SETUP_AREA);
        end
    end

    // ---------------------------------------------------------------
    // APB slave: one wait-free access phase after each setup cycle
    // ---------------------------------------------------------------
    assign apb_wr = psel && penable && pready_r && pwrite;
    assign apb_rd = psel && !penable;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= apb_rd;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            if (apb_rd) begin
                unique case (paddr)
                    CTRL_ADDR:     prdata_r <= {26'h0, ctrl_r};
                    STATUS_ADDR:   prdata_r <= {29'h0, ips_r, sdbs_r, dss_r};
                    TASKFILE_ADDR: prdata_r <= {16'h0, tf_err_r, tf_sts_r};
                    ACTIVE_ADDR:   prdata_r <= active_r;
                    NOTIFY_ADDR:   prdata_r <= notify_r;
                    COALESCE_ADDR: prdata_r <= ccc_r;
                    FISBASE_ADDR:  prdata_r <= fis_base_r;
                    SLOT_ADDR:     prdata_r <= {20'h0, pmp_cur_r, 3'h0, slot_r[pmp_cur_r]};
                    DMACNT_ADDR:   prdata_r <= dma_cnt_r[pmp_cur_r];
                    default:       pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    // Control and received-FIS base
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_r     <= CTRL_RESET;
            fis_base_r <= 32'h0000_0000;
        end else if (apb_wr && paddr == CTRL_ADDR) begin
            ctrl_r <= pwdata[CTRL_WIDTH-1:0];
        end else if (apb_wr && paddr == FISBASE_ADDR) begin
            fis_base_r <= {pwdata[31:8], 8'h00};
        end
    end

    // ---------------------------------------------------------------
    // Status flags: write 1 to clear, a hardware set wins the same cycle
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dss_r  <= 1'b0;
            sdbs_r <= 1'b0;
            ips_r  <= 1'b0;
            irq_r  <= 1'b0;
        end else begin
            if (state_r == DS_SETINTR) dss_r <= 1'b1; // [R6]
            else if (apb_wr && paddr == STATUS_ADDR && pwdata[STAT_DSS_BIT]) dss_r <= 1'b0;
            if (state_r == SDB_SETINTR) sdbs_r <= 1'b1; // [R19]
            else if (apb_wr && paddr == STATUS_ADDR && pwdata[STAT_SDBS_BIT]) sdbs_r <= 1'b0;
            if (state_r == DS_SETIS || state_r == SDB_SETIS) ips_r <= 1'b1; // [R7] [R22]
            else if (apb_wr && paddr == STATUS_ADDR && pwdata[STAT_IPS_BIT]) ips_r <= 1'b0;
            // Interrupt held until software clears the summary bit
            if (state_r == DS_GENINTR || state_r == SDB_GENINTR) irq_r <= 1'b1; // [R8]
            else if (apb_wr && paddr == STATUS_ADDR && pwdata[STAT_IPS_BIT]) irq_r <= 1'b0;
        end
    end

    // Task file, active tags, completed mask, notify bits, coalescing count
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tf_sts_r    <= TF_STS_RESET;
            tf_err_r    <= 8'h00;
            active_r    <= 32'h0000_0000;
            completed_r <= 32'h0000_0000;
            notify_r    <= 32'h0000_0000;
            ccc_r       <= 32'h0000_0000;
        end else begin
            if (state_r == SDB_ENTRY) begin
                tf_sts_r    <= (tf_sts_r & ~TF_STS_WRITABLE) | (sdb_r.status & TF_STS_WRITABLE); // [R11]
                tf_err_r    <= sdb_r.error; // [R12]
                active_r    <= active_r & ~sdb_r.sactive; // [R13]
                completed_r <= sdb_r.sactive;
            end else if (apb_wr && paddr == ACTIVE_ADDR) begin
                active_r <= active_r | pwdata;
            end
            // Software clears notify bits by writing 1; the set wins
            if (state_r == SDB_NOTIFY) notify_r[sdb_r.pmp] <= 1'b1; // [R17]
            else if (apb_wr && paddr == NOTIFY_ADDR) notify_r <= notify_r & ~pwdata;
            if (state_r == SDB_CCC) ccc_r <= ccc_r + {26'h0, popcount(completed_r)}; // [R21]
            else if (apb_wr && paddr == COALESCE_ADDR) ccc_r <= 32'h0000_0000;
        end
    end

    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign rx_ready   = rx_ready_r;
    assign mem_req    = mem_req_r;
    assign exit_pulse = exit_r;
    assign irq        = irq_r;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    setup_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R1]
        state_r == DS_ENTRY |-> $past(setup_fis.valid))
        else $error("setup handling without a setup frame");
    setup_store_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R4]
        state_r == DS_ENTRY |=> mem_req_r.valid && !mem_req_r.devbits
            && mem_req_r.addr == fis_base_r + {20'h0, pmp_cur_r, 8'h00} + SETUP_AREA)
        else $error("setup frame store address wrong");
    setup_slot_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R2]
        state_r == DS_ENTRY |=> slot_r[pmp_cur_r] == setup_r.tag
            && dma_cnt_r[pmp_cur_r] == setup_r.count)
        else $error("slot or count not saved");
    setup_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R5]
        state_r == DS_ENTRY && !setup_r.irq |=> state_r == DS_AUTO)
        else $error("setup without irq bit did not go to auto-activate");
    irq_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R8]
        irq_r && !(apb_wr && paddr == STATUS_ADDR && pwdata[STAT_IPS_BIT]) |=> irq_r)
        else $error("interrupt dropped without software clear");
    auto_act_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R9]
        state_r == DS_AUTO && slot_write_bits[slot_r[pmp_cur_r]] && setup_r.auto_act
            |=> exit_r == EXIT_DATA_TX ##1 exit_r == EXIT_NONE)
        else $error("auto-activate did not start data send");
    sdb_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R14]
        state_r == SDB_ENTRY |=> dma_cnt_r[pmp_cur_r] == 32'h0000_0000
            && completed_r == sdb_r.sactive && (active_r & sdb_r.sactive) == 32'h0)
        else $error("device-bits updates missing");
    fatal_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R15]
        state_r == SDB_DECIDE && tf_sts_r[TF_ERR_BIT] |=> exit_r == EXIT_FATAL_TF)
        else $error("task-file error not taken first");
    notify_entry_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R18]
        state_r == SDB_NOTIFY |-> sdb_r.notify && ctrl_r[CTRL_NTF_BIT]
            ##1 state_r == SDB_SETINTR && notify_r[sdb_r.pmp])
        else $error("notify step entered or left wrongly");
    ccc_add_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R21]
        state_r == SDB_CCC |=> ccc_r == $past(ccc_r) + {26'h0, popcount(completed_r)})
        else $error("coalescing count not advanced");
    sdb_tail_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R23]
        state_r == SDB_GENINTR && !mask_zero |=> exit_r == EXIT_POWER_CHECK && irq_r)
        else $error("device-bits interrupt exit wrong");

endmodule

`default_nettype wire

// [core/fis_rx_pkg.sv]
/*
 * Shared constants and carriers for the per-port receive handler of
 * DMA Setup and Set Device Bits frames.
 * Assumes a 32-bit APB register port and word-aligned register offsets.
 */
package fis_rx_pkg;

    // ---------------------------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR     = 8'h00;
    localparam logic [7:0] STATUS_ADDR   = 8'h04;
    localparam logic [7:0] TASKFILE_ADDR = 8'h08;
    localparam logic [7:0] ACTIVE_ADDR   = 8'h0c;
    localparam logic [7:0] NOTIFY_ADDR   = 8'h10;
    localparam logic [7:0] COALESCE_ADDR = 8'h14;
    localparam logic [7:0] FISBASE_ADDR  = 8'h18;
    localparam logic [7:0] SLOT_ADDR     = 8'h1c;
    localparam logic [7:0] DMACNT_ADDR   = 8'h20;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTRL_GIE_BIT   = 0;
    localparam int CTRL_DSE_BIT   = 1;
    localparam int CTRL_SDBE_BIT  = 2;
    localparam int CTRL_FBS_BIT   = 3;
    localparam int CTRL_NTF_BIT   = 4;
    localparam int CTRL_CCC_BIT   = 5;
    localparam int CTRL_WIDTH     = 6;
    localparam int STAT_DSS_BIT   = 0;
    localparam int STAT_SDBS_BIT  = 1;
    localparam int STAT_IPS_BIT   = 2;
    localparam int TF_ERR_BIT     = 0;
    localparam int TF_ERRF_LSB    = 8;
    localparam int SLOT_PMP_LSB   = 8;

    // Status bits 7 and 3 are reserved and never loaded from a frame
    localparam logic [7:0] TF_STS_WRITABLE = 8'h77;

    // ---------------------------------------------------------------
    // Reset values and received-FIS area layout
    // ---------------------------------------------------------------
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET   = 6'h00;
    localparam logic [7:0]            TF_STS_RESET = 8'h7f;
    localparam logic [31:0]           PMP_STRIDE   = 32'h0000_0100;
    localparam logic [31:0]           SETUP_AREA   = 32'h0000_0000;
    localparam logic [31:0]           DEVBITS_AREA = 32'h0000_0040;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [3:0]  pmp;
        logic [4:0]  tag;
        logic [31:0] count;
        logic        irq;
        logic        auto_act;
    } setup_frame_type;

    typedef struct packed {
        logic        valid;
        logic [3:0]  pmp;
        logic [7:0]  status;
        logic [7:0]  error;
        logic [31:0] sactive;
        logic        irq;
        logic        notify;
    } devbits_frame_type;

    typedef struct packed {
        logic        valid;
        logic        devbits;
        logic [31:0] addr;
    } mem_req_type;

    typedef enum logic [2:0] {
        EXIT_NONE,
        EXIT_DATA_TX,
        EXIT_SWITCH_IDLE,
        EXIT_PORT_IDLE,
        EXIT_POWER_CHECK,
        EXIT_FATAL_TF
    } exit_type;

endpackage
